// *** core/timer1_consts.svh ***
`ifndef TIMER1_CONSTS_SVH
`define TIMER1_CONSTS_SVH

// Byte addresses on the register bus.
`define ADDR_CONTROL 8'h00
`define ADDR_COMPARE_A 8'h04
`define ADDR_COMPARE_B 8'h08
`define ADDR_COUNTER 8'h0C
`define ADDR_IRQ_STATUS 8'h10
`define ADDR_IRQ_MASK 8'h14
`define ADDR_STATUS 8'h18

// Control register field positions.
`define CTL_START_LO 0
`define CTL_CLK_LO 2
`define CTL_MODE_LO 4
`define CTL_CAPTURE_BIT 6
`define CTL_FLIPFLOP_BIT 7

// Reset values.
`define CONTROL_RESET 8'h00
`define COMPARE_RESET 16'hFFFF
`define COUNTER_RESET 16'h0000

// Source clock divisors as terminal counts of a free running divider, and the count step.
`define DIV_2048_LAST 11'h7FF
`define DIV_128_LAST 11'h07F
`define DIV_8_LAST 11'h007
`define ONE_COUNT 16'h0001

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** core/timer1_pkg.sv ***
package timer1_pkg;
    // Source clock selection codes.
    typedef enum logic [1:0] {
        SRC_DIV2048 = 2'h0,
        SRC_DIV128 = 2'h1,
        SRC_DIV8 = 2'h2,
        SRC_PIN = 2'h3
    } src_sel_t;

    // Operating mode codes.
    typedef enum logic [1:0] {
        MODE_TIMER = 2'h0,
        MODE_WINDOW = 2'h1,
        MODE_PULSE_WIDTH = 2'h2,
        MODE_PULSE_OUT = 2'h3
    } op_mode_t;

    // Control register layout.
    typedef struct packed {
        logic flipflop;
        logic capture;
        op_mode_t mode;
        src_sel_t clk;
        logic [1:0] start;
    } control_t;

    // Write channel state.
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_RESP = 3'b010,
        WR_DONE = 3'b100
    } wr_state_t;

    // Bus slave outputs travel together.
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } bus_out_t;
endpackage : timer1_pkg

// *** core/timer1_prescaler.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "timer1_consts.svh"
module timer1_prescaler
    import timer1_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // Selection.
    input wire logic slow_divider_select,
    input wire logic slow_mode,
    input wire src_sel_t sel,
    input wire logic pin_rise,
    // Tick out, one cycle per source clock edge.
    output logic tick
);
    logic [10:0] div_r;
    logic [10:0] last;

    // Free running divider; the slow path divides by 8 as the slow clock stand-in.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            div_r <= 11'h000;
        end else if (clk_en) begin
            div_r <= div_r + 11'h001;
        end
    end

    // Pick the terminal count for the selected source.
    always_comb begin
        unique case (sel)
            SRC_DIV2048: last = (slow_divider_select || slow_mode) ? `DIV_8_LAST : `DIV_2048_LAST;
            SRC_DIV128: last = `DIV_128_LAST;
            SRC_DIV8: last = `DIV_8_LAST;
            SRC_PIN: last = `DIV_8_LAST;
        endcase
        if (sel == SRC_PIN) begin
            tick = clk_en && pin_rise;
        end else begin
            tick = clk_en && ((div_r & last) == last);
        end
    end
endmodule : timer1_prescaler
`default_nettype wire

// *** core/timer1_counter.sv ***
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer1_consts.svh"
module timer1_counter
    import timer1_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // AXI4-Lite write channels.
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels.
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device pins and system controls.
    input wire logic ext_clk_pin,
    input wire logic stop_entry,
    input wire logic slow_divider_select,
    input wire logic slow_mode,
    // Interrupt.
    output logic irq
);
    typedef struct packed {
        bus_out_t bus;
        wr_state_t wst;
        logic [7:0] awaddr;
        logic aw_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_got;
        control_t ctl;
        logic [15:0] a_buf;
        logic [15:0] b_buf;
        logic a_pend;
        logic b_pend;
        logic [15:0] a_act;
        logic [15:0] b_act;
        logic [15:0] count;
        logic [1:0] pin_sync;
        logic pin_prev;
        logic sts;
        logic msk;
        logic irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;
    logic tick;
    logic pin_rise;
    logic running;
    logic do_wr;
    logic match;

    assign pin_rise = s_r.pin_sync[1] && !s_r.pin_prev;
    assign running = (s_r.ctl.start != 2'h0);

    timer1_prescaler u_pre (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .clk_en(clk_en),
        .slow_divider_select(slow_divider_select),
        .slow_mode(slow_mode),
        .sel(s_r.ctl.clk),
        .pin_rise(pin_rise),
        .tick(tick)
    );

    // Next state for bus, registers and counter.
    always_comb begin
        s_nxt = s_r;
        do_wr = 1'b0;
        match = 1'b0;
        s_nxt.pin_sync = {s_r.pin_sync[0], ext_clk_pin};
        s_nxt.pin_prev = s_r.pin_sync[1];
        // Write address and data are taken in either order.
        if (s_r.bus.awready && s_axi_awvalid) begin
            s_nxt.awaddr = s_axi_awaddr;
            s_nxt.aw_got = 1'b1;
            s_nxt.bus.awready = 1'b0;
        end
        if (s_r.bus.wready && s_axi_wvalid) begin
            s_nxt.wdata = s_axi_wdata;
            s_nxt.wstrb = s_axi_wstrb;
            s_nxt.w_got = 1'b1;
            s_nxt.bus.wready = 1'b0;
        end
        unique case (s_r.wst)
            WR_IDLE: if (s_r.aw_got && s_r.w_got) begin
                s_nxt.wst = WR_RESP;
            end
            WR_RESP: begin
                do_wr = 1'b1;
                s_nxt.bus.bvalid = 1'b1;
                s_nxt.bus.bresp = `RESP_OKAY;
                s_nxt.wst = WR_DONE;
            end
            WR_DONE: if (s_axi_bready) begin
                s_nxt.bus.bvalid = 1'b0;
                s_nxt.aw_got = 1'b0;
                s_nxt.w_got = 1'b0;
                s_nxt.bus.awready = 1'b1;
                s_nxt.bus.wready = 1'b1;
                s_nxt.wst = WR_IDLE;
            end
        endcase
        // Register writes.
        if (do_wr) begin
            case (s_r.awaddr)
                `ADDR_CONTROL: if (s_r.wstrb[0]) begin
                    s_nxt.ctl = control_t'(s_r.wdata[7:0]);
                end
                `ADDR_COMPARE_A: begin
                    if (s_r.wstrb[0]) s_nxt.a_buf[7:0] = s_r.wdata[7:0];
                    if (s_r.wstrb[1]) begin
                        s_nxt.a_buf[15:8] = s_r.wdata[15:8];
                        s_nxt.a_pend = 1'b1;
                    end
                end
                `ADDR_COMPARE_B: if (s_r.ctl.mode == MODE_PULSE_OUT) begin
                    if (s_r.wstrb[0]) s_nxt.b_buf[7:0] = s_r.wdata[7:0];
                    if (s_r.wstrb[1]) begin
                        s_nxt.b_buf[15:8] = s_r.wdata[15:8];
                        s_nxt.b_pend = 1'b1;
                    end
                end
                `ADDR_IRQ_MASK: if (s_r.wstrb[0]) s_nxt.msk = s_r.wdata[0];
                `ADDR_STATUS: ;
                default: s_nxt.bus.bresp = `RESP_SLVERR;
            endcase
        end
        // Read channel; a read of the interrupt status register clears the sticky bit.
        if (s_r.bus.rvalid) begin
            if (s_axi_rready) s_nxt.bus.rvalid = 1'b0;
            s_nxt.bus.arready = s_axi_rready;
        end else if (s_r.bus.arready && s_axi_arvalid) begin
            s_nxt.bus.arready = 1'b0;
            s_nxt.bus.rvalid = 1'b1;
            s_nxt.bus.rresp = `RESP_OKAY;
            s_nxt.bus.rdata = 32'h00000000;
            case (s_axi_araddr)
                `ADDR_CONTROL: s_nxt.bus.rdata[7:0] = s_r.ctl;
                `ADDR_COMPARE_A: s_nxt.bus.rdata[15:0] = s_r.a_act;
                `ADDR_COMPARE_B: s_nxt.bus.rdata[15:0] = s_r.b_act;
                `ADDR_COUNTER: s_nxt.bus.rdata[15:0] = s_r.count;
                `ADDR_IRQ_STATUS: begin
                    s_nxt.bus.rdata[0] = s_r.sts;
                    s_nxt.sts = 1'b0;
                end
                `ADDR_IRQ_MASK: s_nxt.bus.rdata[0] = s_r.msk;
                `ADDR_STATUS: s_nxt.bus.rdata[0] = running;
                default: s_nxt.bus.rresp = `RESP_SLVERR;
            endcase
        end
        // Buffered compare values load on a source edge after the upper byte.
        if (tick && s_r.a_pend) begin
            s_nxt.a_act = s_r.a_buf;
            s_nxt.a_pend = 1'b0;
        end
        if (tick && s_r.b_pend) begin
            s_nxt.b_act = s_r.b_buf;
            s_nxt.b_pend = 1'b0;
        end
        // Counter: stopped clears, running in timer mode counts and compares.
        if (!running) begin
            s_nxt.count = `COUNTER_RESET;
        end else if (tick && s_r.ctl.mode == MODE_TIMER) begin
            if (s_r.count == s_r.a_act) begin
                match = 1'b1;
                s_nxt.count = `COUNTER_RESET;
            end else begin
                s_nxt.count = s_r.count + `ONE_COUNT;
            end
            if (s_r.ctl.capture) begin
                s_nxt.b_act = s_r.count;
            end
        end
        // Sticky status; a new match wins over the read clear.
        if (match) s_nxt.sts = 1'b1;
        // Standby entry forces the start field to zero.
        if (stop_entry) begin
            s_nxt.ctl.start = 2'h0;
            s_nxt.count = `COUNTER_RESET;
        end
        s_nxt.irq = s_nxt.sts && s_r.msk;
    end

    // State register with synchronous reset and clock enable.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_r <= '0;
            s_r.wst <= WR_IDLE;
            s_r.bus.awready <= 1'b1;
            s_r.bus.wready <= 1'b1;
            s_r.bus.arready <= 1'b1;
            s_r.ctl <= control_t'(`CONTROL_RESET);
            s_r.a_buf <= `COMPARE_RESET;
            s_r.b_buf <= `COMPARE_RESET;
            s_r.a_act <= `COMPARE_RESET;
            s_r.b_act <= `COMPARE_RESET;
        end else if (clk_en) begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register.
    assign s_axi_awready = s_r.bus.awready;
    assign s_axi_wready = s_r.bus.wready;
    assign s_axi_bvalid = s_r.bus.bvalid;
    assign s_axi_bresp = s_r.bus.bresp;
    assign s_axi_arready = s_r.bus.arready;
    assign s_axi_rvalid = s_r.bus.rvalid;
    assign s_axi_rdata = s_r.bus.rdata;
    assign s_axi_rresp = s_r.bus.rresp;
    assign irq = s_r.irq;

    // Match restarts the count from zero on the next edge.
    AST_MATCH_CLEAR: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && tick && running && !stop_entry && s_r.ctl.mode == MODE_TIMER
         && s_r.count == s_r.a_act) |=> (s_r.count == 16'h0000 && s_r.sts))
        else $error("counter not cleared on match");
    // Counting advances by one per source tick.
    AST_COUNT_UP: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && tick && running && !stop_entry && s_r.ctl.mode == MODE_TIMER
         && s_r.count != s_r.a_act) |=> (s_r.count == $past(s_r.count) + 16'h0001))
        else $error("counter did not advance");
    // Capture copies the running count.
    AST_CAPTURE: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && tick && running && s_r.ctl.capture && s_r.ctl.mode == MODE_TIMER)
        |=> (s_r.b_act == $past(s_r.count)))
        else $error("capture missed");
    // Active compare A changes only at a source tick.
    AST_BUFFERED: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!tick) |=> $stable(s_r.a_act))
        else $error("compare A changed without a tick");
    // Active compare B moves only at a source tick, by a load or by a capture.
    AST_B_BUFFERED: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!tick) |=> $stable(s_r.b_act))
        else $error("compare B changed without a tick");
    // Without an upper byte pending the active value holds.
    AST_LOWER_ONLY: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!s_r.a_pend && !(do_wr && s_r.awaddr == `ADDR_COMPARE_A)) |=> $stable(s_r.a_act))
        else $error("compare A changed without upper write");
    // A match sets the sticky status even when a status read clears it.
    AST_STS_SET: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && match) |=> s_r.sts)
        else $error("match did not set status");
    // An unmasked status that no read clears keeps the line high.
    AST_IRQ_LEVEL: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && s_r.sts && s_r.msk
         && !(s_r.bus.arready && !s_r.bus.rvalid && s_axi_arvalid
              && s_axi_araddr == `ADDR_IRQ_STATUS)) |=> irq)
        else $error("interrupt line dropped");
    // Standby clears start.
    AST_STOP: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && stop_entry) |=> (s_r.ctl.start == 2'h0 && s_r.count == 16'h0000))
        else $error("standby did not stop timer");
    // A stopped counter sits at zero.
    AST_HALTED: assert property (@(posedge ref_clk) disable iff (!rstn)
        (clk_en && !running) |=> (s_r.count == `COUNTER_RESET))
        else $error("stopped counter not at zero");
    // A pin tick needs the pin low three edges back and high two edges back.
    AST_PIN_SRC: assert property (@(posedge ref_clk) disable iff (!rstn)
        (s_r.ctl.clk == SRC_PIN && tick && $past(clk_en) && $past(clk_en, 2)
         && $past(clk_en, 3) && $past(rstn, 3))
        |-> ($past(ext_clk_pin, 2) && !$past(ext_clk_pin, 3)))
        else $error("pin source tick without edge");
    // Only timer mode moves the counter.
    AST_MODE: assert property (@(posedge ref_clk) disable iff (!rstn)
        (running && s_r.ctl.mode != MODE_TIMER && !stop_entry) |=> $stable(s_r.count))
        else $error("counter moved outside timer mode");
    COV_MATCH: cover property (@(posedge ref_clk) match);
    COV_CAPTURE: cover property (@(posedge ref_clk) tick && s_r.ctl.capture && running);
    COV_STOP: cover property (@(posedge ref_clk) stop_entry && running);
    COV_B_LOAD: cover property (@(posedge ref_clk) tick && s_r.b_pend);
endmodule : timer1_counter
`default_nettype wire

// *** test/sixteen_bit_timer_counter_one_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_timer_counter_one_tb;
    import timer1_pkg::*;
    // Clock, reset and bus master signals.
    logic ref_clk = 1'b0, rstn = 1'b0, clk_en = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp;
    logic ext_clk_pin = 1'b0, stop_entry = 1'b0, slow_divider_select = 1'b0, slow_mode = 1'b0;
    int bad_count = 0, total_checks = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    logic seen;
    // Reset table: address, expected data, expected response.
    typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} row_t;
    row_t rows [8] = '{'{8'h00, 32'h0, 2'h0}, '{8'h04, 32'hFFFF, 2'h0},
        '{8'h08, 32'hFFFF, 2'h0}, '{8'h0C, 32'h0, 2'h0}, '{8'h10, 32'h0, 2'h0},
        '{8'h14, 32'h0, 2'h0}, '{8'h18, 32'h0, 2'h0}, '{8'h1C, 32'h0, 2'h2}};

    // The clock toggles every half period of 4 ns.
    always #4 ref_clk = ~ref_clk;

    timer1_counter dut (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ext_clk_pin(ext_clk_pin),
        .stop_entry(stop_entry), .slow_divider_select(slow_divider_select),
        .slow_mode(slow_mode), .irq(irq));

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // A wait that ran out counts as a mismatch and closes the run.
    task automatic hang();
        bad_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
        stop_test();
    endtask : hang

    // One AXI4-Lite write; address and data are offered together.
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 100) hang();
        rs = bresp;
        bready <= 1'b0;
        @(posedge ref_clk);
    endtask : wr

    // One AXI4-Lite read; data and response are taken at the handshake edge.
    task automatic rdr(input logic [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 100) hang();
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        @(posedge ref_clk);
    endtask : rdr

    // Waits a number of clock edges.
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    initial begin
        int i;
        cyc(2);
        rstn <= 1'b1;
        @(posedge ref_clk);
        // Register reset values and the unmapped address.
        foreach (rows[k]) begin
            rdr(rows[k].a);
            chk({30'h0, rs}, {30'h0, rows[k].r});
            if (rows[k].r == 2'h0) chk(rd, rows[k].d);
        end
        // Timer mode on divide by 8, compare A of 5, interrupt unmasked.
        wr(8'h04, 32'h0005, 4'h3);
        wr(8'h14, 32'h1, 4'hF);
        wr(8'h00, 32'h09, 4'hF);
        for (i = 0; i < 400 && irq !== 1'b1; i++) @(posedge ref_clk);
        if (i == 400) hang();
        for (i = 0; i < 12; i++) begin
            rdr(8'h0C);
            chk({31'h0, rd <= 32'h5}, 32'h1);
        end
        rdr(8'h10);
        chk(rd, 32'h1);
        cyc(1);
        chk({31'h0, irq}, 32'h0);
        // A masked match still sets status but leaves the line low.
        wr(8'h14, 32'h0, 4'hF);
        cyc(60);
        chk({31'h0, irq}, 32'h0);
        rdr(8'h10);
        chk(rd, 32'h1);
        // A lower byte alone must not change the active compare value.
        wr(8'h04, 32'h0002, 4'h1);
        seen = 1'b0;
        for (i = 0; i < 30; i++) begin
            rdr(8'h0C);
            if (rd > 32'h2 && rd <= 32'h5) seen = 1'b1;
        end
        chk({31'h0, seen}, 32'h1);
        // The upper byte write arms the new value of 2.
        wr(8'h04, 32'h0002, 4'h2);
        cyc(20);
        for (i = 0; i < 12; i++) begin
            rdr(8'h0C);
            chk({31'h0, rd <= 32'h2}, 32'h1);
        end
        // Auto capture follows the running count.
        wr(8'h00, 32'h49, 4'hF);
        cyc(20);
        rdr(8'h08);
        chk({31'h0, rd <= 32'h2}, 32'h1);
        // Standby entry clears the start field and the count.
        stop_entry <= 1'b1;
        @(posedge ref_clk);
        stop_entry <= 1'b0;
        cyc(2);
        rdr(8'h00);
        chk(rd, 32'h48);
        cyc(30);
        rdr(8'h0C);
        chk(rd, 32'h0);
        rdr(8'h18);
        chk(rd, 32'h0);
        // Pin clock: three rising edges give a count of three.
        wr(8'h04, 32'h0005, 4'h3);
        wr(8'h00, 32'h0C, 4'hF);
        wr(8'h00, 32'h0D, 4'hF);
        for (i = 0; i < 6; i++) begin
            ext_clk_pin <= ~ext_clk_pin;
            cyc(8);
        end
        rdr(8'h0C);
        chk(rd, 32'h3);
        // Clock enable low freezes everything, so a pin pulse meanwhile is lost.
        clk_en <= 1'b0;
        ext_clk_pin <= 1'b1;
        cyc(8);
        ext_clk_pin <= 1'b0;
        cyc(8);
        clk_en <= 1'b1;
        rdr(8'h0C);
        chk(rd, 32'h3);
        // Window mode does not run the plain timer path.
        wr(8'h00, 32'h00, 4'hF);
        wr(8'h00, 32'h18, 4'hF);
        wr(8'h00, 32'h1A, 4'hF);
        cyc(40);
        rdr(8'h0C);
        chk(rd, 32'h0);
        // Pulse output mode: flip-flop set before start, compare B written after the mode.
        wr(8'h00, 32'h00, 4'hF);
        wr(8'h00, 32'hB8, 4'hF);
        wr(8'h08, 32'h0003, 4'h3);
        cyc(20);
        rdr(8'h08);
        chk(rd, 32'h3);
        wr(8'h00, 32'h00, 4'hF);
        // Unmasking a pending match status raises the line.
        wr(8'h14, 32'h1, 4'hF);
        chk({31'h0, irq}, 32'h1);
        // A reset in mid-run returns the bus, the line and the registers to reset values.
        rstn <= 1'b0;
        cyc(2);
        rstn <= 1'b1;
        chk({27'h0, awready, wready, arready, bvalid, rvalid}, 32'h1C);
        chk({31'h0, irq}, 32'h0);
        @(posedge ref_clk);
        rdr(8'h00);
        chk(rd, 32'h0);
        rdr(8'h04);
        chk(rd, 32'hFFFF);
        rdr(8'h10);
        chk(rd, 32'h0);
        // The slow divider option turns source 00 into a divide by 8.
        slow_divider_select <= 1'b1;
        wr(8'h00, 32'h01, 4'hF);
        cyc(40);
        rdr(8'h0C);
        chk({31'h0, rd >= 32'h4 && rd <= 32'h7}, 32'h1);
        slow_divider_select <= 1'b0;
        stop_test();
    end
endmodule : sixteen_bit_timer_counter_one_tb
`default_nettype wire
